// file: rtl/lrwfs_pkg.sv
// Shared constants of the low-rate PAN framer and energy scan block
package lrwfs_pkg;
	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] OFF_TASKS   = 12'h000;
	localparam logic [11:0] OFF_EVENTS  = 12'h004;
	localparam logic [11:0] OFF_CTRL    = 12'h008;
	localparam logic [11:0] OFF_SFD     = 12'h00C;
	localparam logic [11:0] OFF_PTR     = 12'h010;
	localparam logic [11:0] OFF_ED_ITER = 12'h014;
	localparam logic [11:0] OFF_ED_RES  = 12'h018;
	localparam logic [11:0] OFF_CRC_ST  = 12'h01C;
	localparam logic [11:0] OFF_RX_INFO = 12'h020;
	localparam logic [11:0] OFF_STATUS  = 12'h024;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int TSK_TX_START = 0;
	localparam int TSK_ED_START = 2;
	localparam int TSK_ED_STOP  = 3;
	localparam int EV_FRM_BEGIN = 0;
	localparam int EV_FRM_END   = 1;
	localparam int EV_ED_DONE   = 2;
	localparam int EV_ED_HALT   = 3;
	localparam int EV_TX_DONE   = 4;
	localparam int EV_W         = 5;
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_CRC_EN   = 4;
	localparam int CTL_ASSIST   = 5;
	localparam int CTL_RX_EN    = 6;
	localparam int CTL_W        = 7;
	// ------------------------------------------------------------------
	// Values and reset values
	// ------------------------------------------------------------------
	localparam logic [3:0]  LRWPAN_250K_MODE_VALUE = 4'hF;
	localparam logic [7:0]  SFD_RESET     = 8'hA7;
	localparam logic [6:0]  CTRL_RESET    = 7'h00;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [15:0] CRC_INIT      = 16'h0000;
	localparam logic [15:0] CRC_RESIDUE   = 16'h0000;
	localparam logic [1:0]  PREAMBLE_LAST = 2'h3;
	localparam logic [6:0]  MAX_PSDU      = 7'h7F;
	localparam logic [6:0]  MAX_PAYLOAD_CRC = 7'h7D;
	localparam logic [6:0]  FCS_OCTETS    = 7'h02;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ     = 250;
	localparam int SYMBOL_US   = 16;
	localparam int ED_TIME_US  = 128;
	localparam int SYMBOL_CYC  = SYMBOL_US * CLK_MHZ;
	localparam int ED_SYMBOLS  = ED_TIME_US / SYMBOL_US;
	localparam logic [2:0] ED_SYM_LAST = 3'(ED_SYMBOLS - 1);
endpackage : lrwfs_pkg

// file: rtl/lrwfs_crc16.sv
// Octet-wide 16-bit FCS engine, LSB first
`timescale 1ns/10ps
`default_nettype none
module lrwfs_crc16 (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        init_i,
	input  wire logic        en_i,
	input  wire logic [7:0]  data_i,
	output logic      [15:0] crc_o,
	output logic      [15:0] crc_nxt_o
);
	logic [15:0] crc_q;

	always_comb begin
		logic [15:0] c;
		c = crc_q;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ data_i[i]) begin
				c = (c >> 1) ^ lrwfs_pkg::CRC_POLY_REFL;
			end else begin
				c = c >> 1;
			end
		end
		crc_nxt_o = c;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || init_i) begin
			crc_q <= lrwfs_pkg::CRC_INIT;
		end else if (en_i) begin
			crc_q <= crc_nxt_o;
		end
	end

	assign crc_o = crc_q;
endmodule : lrwfs_crc16
`default_nettype wire

// file: rtl/lrwfs_top.sv
// Low-rate PAN framer, deframer and energy scan with APB registers
// Functional notes
// - PHY logic acts only when mode field holds the 250k PAN value; a transmit or scan already under way runs on if it changes.
// - Symbol period is sixteen microseconds for all symbol timing.
// - PSDU at most 127 octets; 125 usable with automatic CRC.
// - Transmit four all-zero preamble octets before the delimiter.
// - Delimiter resets to 0xA7, programmable; receive matches programmed value.
// - Preamble and delimiter come from hardware, never from memory.
// - Length header reported with all eight bits; length is low seven.
// - Length header is first byte at frame pointer, both directions.
// - Zero-length received frames dropped without a frame-begin event.
// - Exactly N octets follow the header; last two are FCS with CRC.
// - With CRC on, append FCS on transmit, check and record on receive.
// - Each energy measurement averages RSSI over eight symbols.
// - Scan starts on start task, ends with done event and result.
// - Nonzero iteration count runs that many measurements, reports maximum.
// - Stop task aborts scan and raises halted event afterwards.
// - In assisted mode the two frame-control octets are captured.
// - With CRC, received FCS is not stored; transmit fetches length minus two.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module lrwfs_top #(
	parameter int unsigned SYM_CYC = lrwfs_pkg::SYMBOL_CYC
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic      [31:0] MEM_ADDR_O,
	output logic             MEM_RE_O,
	output logic             MEM_WE_O,
	output logic      [7:0]  MEM_WDATA_O,
	input  wire logic [7:0]  MEM_RDATA_I,
	output logic      [7:0]  TX_DATA_O,
	output logic             TX_VALID_O,
	input  wire logic        TX_READY_I,
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic        RX_VALID_I,
	input  wire logic [7:0]  RSSI_I
);
	typedef enum logic [6:0] {
		T_IDLE = 7'b000_0001, T_PRE  = 7'b000_0010, T_SFD  = 7'b000_0100,
		T_RD   = 7'b000_1000, T_WAIT = 7'b001_0000, T_SEND = 7'b010_0000,
		T_FCS  = 7'b100_0000
	} lrwfs_tx_t;
	typedef enum logic [2:0] {
		R_HUNT = 3'b001, R_LEN = 3'b010, R_DATA = 3'b100
	} lrwfs_rx_t;
	typedef enum logic [1:0] {
		E_IDLE = 2'b01, E_MEAS = 2'b10
	} lrwfs_ed_t;

	// ------------------------------------------------------------------
	// APB slave and registers
	// ------------------------------------------------------------------
	logic [lrwfs_pkg::CTL_W-1:0] ctrl_q;
	logic [7:0]  sfd_q;
	logic [31:0] ptr_q;
	logic [7:0]  iter_q;
	logic [lrwfs_pkg::EV_W-1:0] ev_q, ev_set;
	logic [7:0]  ed_res_q, phr_q;
	logic [15:0] fcf_q;
	logic [1:0]  crc_st_q;
	logic [31:0] prdata_q, rd_mux;
	logic        hit, wr, mode_ok, crc_on;
	lrwfs_tx_t   tx_q;
	lrwfs_rx_t   rx_q;
	lrwfs_ed_t   ed_q;

	assign wr       = PSEL_I & PENABLE_I & PWRITE_I;
	assign PREADY_O = 1'b1;
	assign PRDATA_O = prdata_q;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
	assign mode_ok  = ctrl_q[lrwfs_pkg::CTL_MODE_LSB +: 4] == lrwfs_pkg::LRWPAN_250K_MODE_VALUE;
	assign crc_on   = ctrl_q[lrwfs_pkg::CTL_CRC_EN];

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (PADDR_I)
			lrwfs_pkg::OFF_TASKS:   rd_mux = 32'h0000_0000;
			lrwfs_pkg::OFF_EVENTS:  rd_mux = {27'h000_0000, ev_q};
			lrwfs_pkg::OFF_CTRL:    rd_mux = {25'h000_0000, ctrl_q};
			lrwfs_pkg::OFF_SFD:     rd_mux = {24'h00_0000, sfd_q};
			lrwfs_pkg::OFF_PTR:     rd_mux = ptr_q;
			lrwfs_pkg::OFF_ED_ITER: rd_mux = {24'h00_0000, iter_q};
			lrwfs_pkg::OFF_ED_RES:  rd_mux = {24'h00_0000, ed_res_q};
			lrwfs_pkg::OFF_CRC_ST:  rd_mux = {30'h0000_0000, crc_st_q};
			lrwfs_pkg::OFF_RX_INFO: rd_mux = {8'h00, fcf_q, phr_q};
			lrwfs_pkg::OFF_STATUS:  rd_mux = {29'h0000_0000, ed_q == E_MEAS,
			                                  rx_q != R_HUNT, tx_q != T_IDLE};
			default:                hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup phase so the zero-wait access sees it
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			prdata_q <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ctrl_q <= lrwfs_pkg::CTRL_RESET;
			sfd_q  <= lrwfs_pkg::SFD_RESET;
			ptr_q  <= 32'h0000_0000;
			iter_q <= 8'h00;
		end else if (wr) begin
			case (PADDR_I)
				lrwfs_pkg::OFF_CTRL:    ctrl_q <= PWDATA_I[lrwfs_pkg::CTL_W-1:0];
				lrwfs_pkg::OFF_SFD:     sfd_q  <= PWDATA_I[7:0];
				lrwfs_pkg::OFF_PTR:     ptr_q  <= PWDATA_I;
				lrwfs_pkg::OFF_ED_ITER: iter_q <= PWDATA_I[7:0];
				default: ;
			endcase
		end
	end

	logic tsk_tx, tsk_ed_go, tsk_ed_stop;
	assign tsk_tx      = wr && PADDR_I == lrwfs_pkg::OFF_TASKS && PWDATA_I[lrwfs_pkg::TSK_TX_START];
	assign tsk_ed_go   = wr && PADDR_I == lrwfs_pkg::OFF_TASKS && PWDATA_I[lrwfs_pkg::TSK_ED_START];
	assign tsk_ed_stop = wr && PADDR_I == lrwfs_pkg::OFF_TASKS && PWDATA_I[lrwfs_pkg::TSK_ED_STOP];

	// Write-one-to-clear events; a set in the clearing cycle survives
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ev_q <= '0;
		end else if (wr && PADDR_I == lrwfs_pkg::OFF_EVENTS) begin
			ev_q <= (ev_q & ~PWDATA_I[lrwfs_pkg::EV_W-1:0]) | ev_set;
		end else begin
			ev_q <= ev_q | ev_set;
		end
	end

	// ------------------------------------------------------------------
	// Shared FCS engine
	// ------------------------------------------------------------------
	logic        crc_init, crc_feed, tx_go, rx_len_ok, rx_byte;
	logic [15:0] crc, crc_nxt;
	logic [6:0]  rx_idx_q, rx_len;

	lrwfs_crc16 u_crc (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.init_i    (crc_init),
		.en_i      (crc_feed),
		.data_i    (tx_q == T_WAIT ? MEM_RDATA_I : RX_DATA_I),
		.crc_o     (crc),
		.crc_nxt_o (crc_nxt)
	);

	// ------------------------------------------------------------------
	// Transmit framer
	// ------------------------------------------------------------------
	logic [1:0]  pre_cnt_q;
	logic [6:0]  tx_idx_q, tx_len_q, tx_fetch;
	logic        fcs_hi_q, tx_last;
	logic [7:0]  tx_data_q;
	logic        tx_valid_q, mem_re_q, mem_we_q;
	logic [31:0] mem_addr_q;
	logic [7:0]  mem_wdata_q;

	// Transmit start task is ignored unless the receiver is outside a frame
	assign tx_go    = tsk_tx && tx_q == T_IDLE && mode_ok && rx_q == R_HUNT;
	// fetch length minus two with CRC
	assign tx_fetch = !crc_on ? tx_len_q :
	                  (tx_len_q >= lrwfs_pkg::FCS_OCTETS) ? tx_len_q - lrwfs_pkg::FCS_OCTETS : 7'h00;
	assign tx_last  = tx_idx_q == tx_fetch;
	assign TX_DATA_O  = tx_data_q;
	assign TX_VALID_O = tx_valid_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			tx_q       <= T_IDLE;
			pre_cnt_q  <= 2'h0;
			tx_idx_q   <= 7'h00;
			tx_len_q   <= 7'h00;
			fcs_hi_q   <= 1'b0;
			tx_data_q  <= 8'h00;
			tx_valid_q <= 1'b0;
		end else begin
			case (tx_q)
				T_IDLE: if (tx_go) begin
					tx_data_q  <= 8'h00;
					tx_valid_q <= 1'b1;
					pre_cnt_q  <= 2'h0;
					tx_q       <= T_PRE;
				end
				T_PRE: if (TX_READY_I) begin
					pre_cnt_q <= pre_cnt_q + 2'h1;
					if (pre_cnt_q == lrwfs_pkg::PREAMBLE_LAST) begin
						tx_data_q <= sfd_q;
						tx_q      <= T_SFD;
					end
				end
				T_SFD: if (TX_READY_I) begin
					tx_valid_q <= 1'b0;
					tx_idx_q   <= 7'h00;
					tx_q       <= T_RD;
				end
				T_RD: tx_q <= T_WAIT;
				T_WAIT: begin
					tx_data_q  <= MEM_RDATA_I;
					tx_valid_q <= 1'b1;
					if (tx_idx_q == 7'h00) begin
						tx_len_q <= MEM_RDATA_I[6:0];
					end
					tx_q <= T_SEND;
				end
				T_SEND: if (TX_READY_I) begin
					tx_valid_q <= 1'b0;
					tx_idx_q   <= tx_idx_q + 7'h01;
					if (!tx_last) begin
						tx_q <= T_RD;
					end else if (crc_on) begin
						tx_data_q  <= crc[7:0];
						tx_valid_q <= 1'b1;
						fcs_hi_q   <= 1'b0;
						tx_q       <= T_FCS;
					end else begin
						tx_q <= T_IDLE;
					end
				end
				T_FCS: if (TX_READY_I) begin
					if (!fcs_hi_q) begin
						tx_data_q <= crc[15:8];
						fcs_hi_q  <= 1'b1;
					end else begin
						tx_valid_q <= 1'b0;
						tx_q       <= T_IDLE;
					end
				end
				default: tx_q <= T_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Receive deframer
	// ------------------------------------------------------------------
	logic rx_act, rx_store;
	assign rx_act    = ctrl_q[lrwfs_pkg::CTL_RX_EN] && mode_ok && tx_q == T_IDLE;
	assign rx_byte   = rx_act && RX_VALID_I;
	assign rx_len    = phr_q[6:0];
	assign rx_len_ok = rx_byte && rx_q == R_LEN && RX_DATA_I[6:0] != 7'h00;
	// FCS octets kept out of memory
	assign rx_store  = !crc_on || rx_len < lrwfs_pkg::FCS_OCTETS ||
	                   rx_idx_q <= rx_len - lrwfs_pkg::FCS_OCTETS;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			rx_q     <= R_HUNT;
			rx_idx_q <= 7'h00;
			phr_q    <= 8'h00;
			fcf_q    <= 16'h0000;
			crc_st_q <= 2'h0;
		end else if (!rx_act) begin
			rx_q <= R_HUNT;
		end else if (RX_VALID_I) begin
			case (rx_q)
				R_HUNT: if (RX_DATA_I == sfd_q) begin
					rx_q <= R_LEN;
				end
				R_LEN: begin
					if (RX_DATA_I[6:0] == 7'h00) begin
						rx_q <= R_HUNT;
					end else begin
						phr_q    <= RX_DATA_I;
						rx_idx_q <= 7'h01;
						rx_q     <= R_DATA;
					end
				end
				R_DATA: begin
					rx_idx_q <= rx_idx_q + 7'h01;
					if (ctrl_q[lrwfs_pkg::CTL_ASSIST] && rx_idx_q == 7'h01) begin
						fcf_q[7:0] <= RX_DATA_I;
					end
					if (ctrl_q[lrwfs_pkg::CTL_ASSIST] && rx_idx_q == 7'h02) begin
						fcf_q[15:8] <= RX_DATA_I;
					end
					if (rx_idx_q == rx_len) begin
						if (crc_on) begin
							crc_st_q <= {1'b1, crc_nxt == lrwfs_pkg::CRC_RESIDUE};
						end
						rx_q <= R_HUNT;
					end
				end
				default: rx_q <= R_HUNT;
			endcase
		end
	end

	assign crc_init = tx_go || rx_len_ok;
	assign crc_feed = (tx_q == T_WAIT && tx_idx_q != 7'h00) || (rx_byte && rx_q == R_DATA);

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			mem_re_q    <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_addr_q  <= 32'h0000_0000;
			mem_wdata_q <= 8'h00;
		end else begin
			mem_re_q <= 1'b0;
			mem_we_q <= 1'b0;
			if ((tx_q == T_SFD || tx_q == T_SEND) && TX_READY_I && !(tx_q == T_SEND && tx_last)) begin
				mem_re_q   <= 1'b1;
				mem_addr_q <= ptr_q + ((tx_q == T_SFD) ? 32'h0000_0000 : 32'(tx_idx_q) + 32'h0000_0001);
			end else if (rx_len_ok || (rx_byte && rx_q == R_DATA && rx_store)) begin
				mem_we_q    <= 1'b1;
				mem_addr_q  <= ptr_q + ((rx_q == R_LEN) ? 32'h0000_0000 : 32'(rx_idx_q));
				mem_wdata_q <= RX_DATA_I;
			end
		end
	end

	assign MEM_RE_O    = mem_re_q;
	assign MEM_WE_O    = mem_we_q;
	assign MEM_ADDR_O  = mem_addr_q;
	assign MEM_WDATA_O = mem_wdata_q;

	// ------------------------------------------------------------------
	// Energy scan
	// ------------------------------------------------------------------
	logic [31:0] sym_cnt_q;
	logic [2:0]  sym_idx_q;
	logic [10:0] acc_q, acc_nxt;
	logic [7:0]  left_q, max_q, avg, best;
	logic        sym_tick, ed_fin;

	assign sym_tick = ed_q == E_MEAS && sym_cnt_q == SYM_CYC - 1;
	assign acc_nxt  = acc_q + {3'h0, RSSI_I};
	assign avg      = acc_nxt[10:3];
	assign best     = (avg > max_q) ? avg : max_q;
	assign ed_fin   = sym_tick && sym_idx_q == lrwfs_pkg::ED_SYM_LAST;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ed_q      <= E_IDLE;
			sym_cnt_q <= 32'h0000_0000;
			sym_idx_q <= 3'h0;
			acc_q     <= 11'h000;
			left_q    <= 8'h00;
			max_q     <= 8'h00;
			ed_res_q  <= 8'h00;
		end else begin
			case (ed_q)
				E_IDLE: if (tsk_ed_go && !tsk_ed_stop && mode_ok) begin
					left_q    <= (iter_q == 8'h00) ? 8'h01 : iter_q;
					sym_cnt_q <= 32'h0000_0000;
					sym_idx_q <= 3'h0;
					acc_q     <= 11'h000;
					max_q     <= 8'h00;
					ed_q      <= E_MEAS;
				end
				E_MEAS: begin
					sym_cnt_q <= sym_tick ? 32'h0000_0000 : sym_cnt_q + 32'h0000_0001;
					if (tsk_ed_stop) begin
						ed_q <= E_IDLE;
					end else if (ed_fin) begin
						sym_idx_q <= 3'h0;
						acc_q     <= 11'h000;
						max_q     <= best;
						left_q    <= left_q - 8'h01;
						if (left_q == 8'h01) begin
							ed_res_q <= best;
							ed_q     <= E_IDLE;
						end
					end else if (sym_tick) begin
						sym_idx_q <= sym_idx_q + 3'h1;
						acc_q     <= acc_nxt;
					end
				end
				default: ed_q <= E_IDLE;
			endcase
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[lrwfs_pkg::EV_FRM_BEGIN] = rx_len_ok;
		ev_set[lrwfs_pkg::EV_FRM_END]   = rx_byte && rx_q == R_DATA && rx_idx_q == rx_len;
		ev_set[lrwfs_pkg::EV_ED_DONE]   = ed_q == E_MEAS && ed_fin && left_q == 8'h01 && !tsk_ed_stop;
		ev_set[lrwfs_pkg::EV_ED_HALT]   = tsk_ed_stop;
		ev_set[lrwfs_pkg::EV_TX_DONE]   = tx_q == T_FCS ? (TX_READY_I && fcs_hi_q) :
		                                  (tx_q == T_SEND && TX_READY_I && tx_last && !crc_on);
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_ed_last;
		ed_q == E_MEAS && ed_fin && left_q == 8'h01 && !tsk_ed_stop;
	endsequence
	sequence s_fcs_lo;
		tx_q == T_SEND && TX_READY_I && tx_last && crc_on;
	endsequence

	property p_pre;
		tx_go |=> TX_VALID_O && TX_DATA_O == 8'h00 && tx_q == T_PRE;
	endproperty
	a_pre: assert property (p_pre) else $error("preamble not started");
	property p_sfd;
		tx_q == T_PRE && TX_READY_I && pre_cnt_q == 2'h3 |=> TX_DATA_O == sfd_q && TX_VALID_O;
	endproperty
	a_sfd: assert property (p_sfd) else $error("delimiter wrong");
	property p_no_fetch;
		(tx_q == T_PRE || tx_q == T_SFD) |-> !MEM_RE_O;
	endproperty
	a_no_fetch: assert property (p_no_fetch) else $error("fetch in sync header");
	property p_zero_len;
		rx_byte && rx_q == R_LEN && RX_DATA_I[6:0] == 7'h00 |=> rx_q == R_HUNT && !MEM_WE_O
			&& $stable(ev_q[lrwfs_pkg::EV_FRM_BEGIN]);
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("zero length kept");
	property p_hdr;
		rx_len_ok |=> MEM_WE_O && MEM_ADDR_O == ptr_q && MEM_WDATA_O == $past(RX_DATA_I)
			&& phr_q == $past(RX_DATA_I) && ev_q[lrwfs_pkg::EV_FRM_BEGIN];
	endproperty
	a_hdr: assert property (p_hdr) else $error("header not stored");
	property p_fcs_skip;
		rx_byte && rx_q == R_DATA && crc_on && rx_len >= 7'h02 && rx_idx_q > rx_len - 7'h02
			|=> !MEM_WE_O;
	endproperty
	a_fcs_skip: assert property (p_fcs_skip) else $error("FCS written");
	property p_fcs_tx;
		s_fcs_lo ##1 (TX_READY_I && tx_q == T_FCS) |=> TX_DATA_O == $past(crc[15:8], 2);
	endproperty
	a_fcs_tx: assert property (p_fcs_tx) else $error("FCS high octet wrong");
	property p_one_run;
		ed_q == E_IDLE && tsk_ed_go && !tsk_ed_stop && mode_ok && iter_q == 8'h00 |=> left_q == 8'h01;
	endproperty
	a_one_run: assert property (p_one_run) else $error("single run count wrong");
	property p_ed_done;
		s_ed_last |=> ed_q == E_IDLE && ev_q[lrwfs_pkg::EV_ED_DONE] && ed_res_q >= $past(max_q);
	endproperty
	a_ed_done: assert property (p_ed_done) else $error("scan end wrong");
	property p_stop;
		tsk_ed_stop |=> ed_q == E_IDLE && ev_q[lrwfs_pkg::EV_ED_HALT];
	endproperty
	a_stop: assert property (p_stop) else $error("stop not honoured");
	property p_psdu;
		rx_q == R_DATA |-> rx_idx_q <= rx_len && rx_idx_q != 7'h00 && rx_len <= lrwfs_pkg::MAX_PSDU;
	endproperty
	a_psdu: assert property (p_psdu) else $error("PSDU index out of range");
	property p_mode;
		!mode_ok |=> tx_q == T_IDLE || $past(tx_q != T_IDLE);
	endproperty
	a_mode: assert property (p_mode) else $error("framer started outside mode");
endmodule : lrwfs_top
`default_nettype wire

// file: test/lrwfs_air_model.sv
// Remote PAN radio model: air-side octet sink and source
`timescale 1ns/10ps
`default_nettype none
module lrwfs_air_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	output logic      [7:0] rx_data_o,
	output logic            rx_valid_o
);
	logic [7:0] txq[$];
	int         pace = 0;
	initial begin
		tx_ready_o = 1'b0;
		rx_data_o  = 8'h00;
		rx_valid_o = 1'b0;
	end
	// Irregular acceptance, so each octet must hold until taken
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			txq.push_back(tx_data_i);
		pace       <= pace + 1;
		tx_ready_o <= (pace % 3) != 1;
	end
	// Idle line shows the inverse of the last octet
	task automatic send(input logic [7:0] b);
		@(posedge clk_i);
		rx_data_o  <= b;
		rx_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_data_o  <= ~b;
		rx_valid_o <= 1'b0;
	endtask : send
endmodule : lrwfs_air_model
`default_nettype wire

// file: test/lrwfs_tb_top.sv
// Self-checking bench of the PAN framer and energy scan block
`timescale 1ns/10ps
`default_nettype none
module lrwfs_tb_top;
	localparam int SYM = 8;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, rd, maddr;
	logic        prdy, perr, err, mre, mwe, txv, txr, rxv;
	logic [7:0]  mwd, txd, rxd, hi, c8;
	logic [7:0]  mrd = 8'h00;
	logic [7:0]  rssi = 8'h00;
	logic [7:0]  mem[256];
	logic [7:0]  wmem[256];
	logic [7:0]  exq[$];
	logic [7:0]  dq[$];
	logic [15:0] c;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          wcnt = 0;
	int          seed = 27831;
	int          t0;

	always #2 clk = ~clk;

	lrwfs_top #(.SYM_CYC(SYM)) DUT (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(prdy), .PSLVERR_O(perr), .MEM_ADDR_O(maddr), .MEM_RE_O(mre),
		.MEM_WE_O(mwe), .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .TX_DATA_O(txd),
		.TX_VALID_O(txv), .TX_READY_I(txr), .RX_DATA_I(rxd), .RX_VALID_I(rxv),
		.RSSI_I(rssi));
	lrwfs_air_model air (.clk_i(clk), .tx_data_i(txd), .tx_valid_i(txv),
		.tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv));

	// Frame memory: one-cycle read latency, read bus wanders when idle
	always @(posedge clk) begin
		mrd <= mre ? mem[maddr[7:0]] : ~mrd;
		if (mwe) begin
			wmem[maddr[7:0]] <= mwd;
			wcnt <= wcnt + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 100);
		if (prdy !== 1'b1)
			bad_count++;
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic wait_ev(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, lrwfs_pkg::OFF_EVENTS, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 2000);
		if (rd[b] !== 1'b1)
			bad_count++;
	endtask : wait_ev

	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] v;
		v = 16'h0000;
		foreach (q[i]) begin
			v = v ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				v = v[0] ? (v >> 1) ^ 16'h8408 : v >> 1;
		end
		return v;
	endfunction : crc

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, lrwfs_pkg::OFF_SFD, 32'h0);
		chk("sfd_reset", 32'h0000_00A7, rd);
		apb(1'b0, 12'h030, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		// Transmit: reserved length bit set, FCS appended
		repeat (3) dq.push_back(8'($random(seed)));
		mem[8'h10] = 8'h85;
		foreach (dq[i]) mem[8'h11 + i] = dq[i];
		c = crc(dq);
		exq = {8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h85};
		foreach (dq[i]) exq.push_back(dq[i]);
		exq.push_back(c[7:0]);
		exq.push_back(c[15:8]);
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h1);
		apb(1'b0, lrwfs_pkg::OFF_STATUS, 32'h0);
		chk("mode_gate", 32'h0, rd);
		apb(1'b1, lrwfs_pkg::OFF_CTRL, 32'h1F);
		apb(1'b1, lrwfs_pkg::OFF_PTR, 32'h10);
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h1);
		wait_ev(lrwfs_pkg::EV_TX_DONE);
		chk("tx_len", exq.size(), air.txq.size());
		foreach (exq[i]) chk("tx_octet", exq[i], air.txq[i]);
		// Receive on a programmed delimiter; empty frame first
		apb(1'b1, lrwfs_pkg::OFF_EVENTS, 32'h1F);
		apb(1'b1, lrwfs_pkg::OFF_SFD, 32'h5A);
		apb(1'b1, lrwfs_pkg::OFF_CTRL, 32'h7F);
		apb(1'b1, lrwfs_pkg::OFF_PTR, 32'h40);
		exq = {8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'hA7, 8'h84};
		foreach (exq[i]) air.send(exq[i]);
		apb(1'b0, lrwfs_pkg::OFF_EVENTS, 32'h0);
		chk("empty_begin", 32'h0, {31'h0, rd[0]});
		dq = {8'($random(seed)), 8'($random(seed))};
		c = crc(dq);
		exq = {8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h84, dq[0], dq[1], c[7:0], c[15:8]};
		foreach (exq[i]) air.send(exq[i]);
		wait_ev(lrwfs_pkg::EV_FRM_END);
		chk("rx_begin", 32'h1, {31'h0, rd[0]});
		chk("rx_writes", 32'h3, wcnt);
		chk("rx_phr", 8'h84, wmem[8'h40]);
		chk("rx_d0", dq[0], wmem[8'h41]);
		chk("rx_d1", dq[1], wmem[8'h42]);
		apb(1'b0, lrwfs_pkg::OFF_CRC_ST, 32'h0);
		chk("crc_status", 32'h3, rd);
		apb(1'b0, lrwfs_pkg::OFF_RX_INFO, 32'h0);
		chk("rx_phr_info", 8'h84, rd[7:0]);
		chk("rx_fcf", {dq[1], dq[0]}, rd[23:8]);
		// Energy scan: single run, then max of two, then abort
		apb(1'b1, lrwfs_pkg::OFF_CTRL, 32'h0F);
		apb(1'b1, lrwfs_pkg::OFF_EVENTS, 32'h1F);
		hi = 8'h80 | 8'($random(seed));
		c8 = hi ^ 8'h80;
		rssi <= c8;
		t0 = cyc;
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h4);
		wait_ev(lrwfs_pkg::EV_ED_DONE);
		chk("scan_time", 32'h1, {31'h0, (cyc - t0) >= 8 * SYM});
		apb(1'b0, lrwfs_pkg::OFF_ED_RES, 32'h0);
		chk("scan_single", c8, rd);
		apb(1'b1, lrwfs_pkg::OFF_EVENTS, 32'h1F);
		apb(1'b1, lrwfs_pkg::OFF_ED_ITER, 32'h2);
		rssi <= hi;
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h4);
		repeat (10 * SYM + SYM / 2) @(posedge clk);
		rssi <= c8;
		wait_ev(lrwfs_pkg::EV_ED_DONE);
		apb(1'b0, lrwfs_pkg::OFF_ED_RES, 32'h0);
		chk("scan_max", hi, rd);
		apb(1'b1, lrwfs_pkg::OFF_EVENTS, 32'h1F);
		apb(1'b1, lrwfs_pkg::OFF_ED_ITER, 32'h0);
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h4);
		apb(1'b1, lrwfs_pkg::OFF_TASKS, 32'h8);
		wait_ev(lrwfs_pkg::EV_ED_HALT);
		chk("halt_no_done", 32'h0, {31'h0, rd[2]});
		apb(1'b0, lrwfs_pkg::OFF_ED_RES, 32'h0);
		chk("halt_result", hi, rd);
		report_and_stop();
	end
endmodule : lrwfs_tb_top
`default_nettype wire
